/* design/asmu_alarm_status_mask_unit.v */
`timescale 1ns/1ps
`include "asmu_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - alarm flags latch until read, clear if gone
// - bit 7 shows busy, never alerts
// - bit 6 local over high setpoint
// - status bit 5 reads zero
// - bit 4 remote above high setpoint
// - bit 3 remote below low setpoint
// - bit 2 diode fault, no alert
// - bit 1 critical, drives alert and critical
// - bit 0 tach count above limit
// - mask bits 7,5,2 read one
// - mask bit 6 blocks local high
// - mask bit 4 blocks remote high
// - mask bit 3 blocks remote low
// - mask bit 1 blocks critical alarm from alert only
// - mask bit 0 blocks tach alarm
// - power-on bit 7 set until ready
// - power-on bits 6:0 read zero
// - comparator mode alert follows live condition
// - critical output holds until below hysteresis
module asmu_alarm_status_mask_unit #(
	parameter TW = 8,
	parameter CW = 16,
	parameter POR_CYCLES = `ASMU_POR_CYCLES
)(
	input wire clk_sys_in,
	input wire nrst_in,
	input wire busy_in,
	input wire [TW-1:0] local_temp_in,
	input wire [TW-1:0] local_high_in,
	input wire [TW-1:0] remote_temp_in,
	input wire [TW-1:0] remote_high_in,
	input wire [TW-1:0] remote_low_in,
	input wire [TW-1:0] critical_limit_in,
	input wire [TW-1:0] critical_hyst_in,
	input wire diode_fault_in,
	input wire [CW-1:0] tach_count_in,
	input wire [CW-1:0] tach_limit_in,
	input wire alert_comparator_select_in,
	input wire [7:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_wdata_in,
	output reg [7:0] reg_rdata_out,
	output wire alert_n_out,
	output wire critical_temp_n_out
);

	// latched alarm flags and their next value
	reg [7:0] flags_r;
	reg [7:0] flags_nxt;
	// stored mask bits; unused positions are never stored
	reg [7:0] mask_r;
	reg [7:0] mask_nxt;
	// critical pin state and its next value
	reg crit_r;
	reg crit_nxt;
	// alert pin state and its next value
	reg alert_r;
	reg alert_nxt;
	// power-on sequence counter and pending flag
	reg [15:0] por_cnt_r;
	reg power_on_pending_r;
	// combinational alarm conditions
	reg [7:0] live;
	// register views as the host sees them
	reg [7:0] status_view;
	reg [7:0] mask_view;
	reg [7:0] por_view;
	reg [7:0] rdata_nxt;
	// critical release point, one bit wider than the temperature
	reg [TW:0] crit_release;
	reg crit_hold;
	// per-alarm gates: high where the alarm may reach the alert pin
	wire [7:0] open_src;
	// decoded register strobes
	wire status_read;
	wire mask_write;
	// alert candidates for the two pin modes
	wire alert_normal;
	wire alert_live;

	////////////////////////////////////////////////////////////////////////////
	// strict unsigned compare shared by every temperature alarm
	function over;
		input [TW-1:0] value;
		input [TW-1:0] limit;
		begin
			over = value > limit;
		end
	endfunction

	// address decode shared by the clear strobe and the mask write; the read mux uses its own case
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = addr == target;
		end
	endfunction

	// any alarm that is both present and let through by its gate
	function any_open;
		input [7:0] src;
		input [7:0] gate;
		begin
			any_open = |(src & gate & `ASMU_ALERT_SRC);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// live alarm conditions from the comparison sources
	always @*
	begin
		live = `ASMU_FLAGS_RESET;
		live[`ASMU_ST_LOCAL_HI] = over(local_temp_in, local_high_in);
		live[`ASMU_ST_REMOTE_HI] = over(remote_temp_in, remote_high_in);
		// below the low setpoint is the same strict compare, operands swapped
		live[`ASMU_ST_REMOTE_LO] = over(remote_low_in, remote_temp_in);
		live[`ASMU_ST_DIODE] = diode_fault_in;
		live[`ASMU_ST_CRIT] = over(remote_temp_in, critical_limit_in);
		// tach count is wider than a temperature, so it keeps its own compare
		live[`ASMU_ST_TACH] = tach_count_in > tach_limit_in;
	end

	// status as the host sees it: busy live, bit 5 zero
	always @*
	begin
		status_view = flags_r & `ASMU_ST_LATCH_MASK;
		status_view[`ASMU_ST_UNUSED] = 1'b0;
		status_view[`ASMU_ST_BUSY] = busy_in;
	end

	// mask as the host sees it: unused bits always one
	always @*
	begin
		mask_view = mask_r | `ASMU_MASK_ONES;
	end

	// power-on status: only the top bit carries information
	always @*
	begin
		por_view = `ASMU_READ_ZERO;
		por_view[`ASMU_POR_BIT] = power_on_pending_r;
	end

	// decoded strobes; a write to status is ignored, it is read-only
	assign status_read = reg_rd_in && hit(reg_addr_in, `ASMU_ADDR_STATUS);
	assign mask_write = reg_wr_in && hit(reg_addr_in, `ASMU_ADDR_MASK);

	////////////////////////////////////////////////////////////////////////////
	// sticky flags: a read drops only what has gone away; a new event wins
	always @*
	begin
		if (status_read)
			flags_nxt = live & `ASMU_ST_LATCH_MASK;
		else
			flags_nxt = (flags_r | live) & `ASMU_ST_LATCH_MASK;
	end

	// flag register
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			flags_r <= `ASMU_FLAGS_RESET;
		else
			flags_r <= flags_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// mask write: only the documented mask bits are stored
	always @*
	begin
		mask_nxt = mask_r;
		if (mask_write)
			mask_nxt = reg_wdata_in & `ASMU_MASK_RW;
	end

	// mask register
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			mask_r <= `ASMU_MASK_RESET;
		else
			mask_r <= mask_nxt;
	end

	// one gate per alarm so each mask bit can be traced on its own
	assign open_src[`ASMU_ST_BUSY] = 1'b0;
	assign open_src[`ASMU_ST_LOCAL_HI] = ~mask_r[`ASMU_ST_LOCAL_HI];
	assign open_src[`ASMU_ST_UNUSED] = 1'b0;
	assign open_src[`ASMU_ST_REMOTE_HI] = ~mask_r[`ASMU_ST_REMOTE_HI];
	assign open_src[`ASMU_ST_REMOTE_LO] = ~mask_r[`ASMU_ST_REMOTE_LO];
	assign open_src[`ASMU_ST_DIODE] = 1'b0;
	assign open_src[`ASMU_ST_CRIT] = ~mask_r[`ASMU_ST_CRIT];
	assign open_src[`ASMU_ST_TACH] = ~mask_r[`ASMU_ST_TACH];

	////////////////////////////////////////////////////////////////////////////
	// critical release point; extra bit flags a hysteresis above the limit
	always @*
	begin
		crit_release = {1'b0, critical_limit_in} - {1'b0, critical_hyst_in};
		// a wrapped release point can never be reached, so the pin holds
		crit_hold = crit_release[TW] || ({1'b0, remote_temp_in} >= crit_release);
	end

	// critical output with hysteresis
	always @*
	begin
		crit_nxt = crit_r;
		if (live[`ASMU_ST_CRIT])
			crit_nxt = 1'b1;
		else if (crit_r && crit_hold)
			crit_nxt = 1'b1;
		else
			crit_nxt = 1'b0;
	end

	// critical register; the diode fault never reaches it
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			crit_r <= 1'b0;
		else
			crit_r <= crit_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// alert candidates: latched flags and the live conditions
	assign alert_normal = any_open(flags_nxt, open_src);
	assign alert_live = any_open(live, open_src);

	// mode select; comparator mode lets the pin drop without a status read
	always @*
	begin
		if (alert_comparator_select_in)
			alert_nxt = alert_live;
		else
			alert_nxt = alert_normal;
	end

	// alert register
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			alert_r <= 1'b0;
		else
			alert_r <= alert_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// power-on sequence counter; the power-on status bit stays set until it expires
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			por_cnt_r <= `ASMU_POR_CNT_RESET;
			power_on_pending_r <= 1'b1;
		end
		else if (power_on_pending_r)
		begin
			if (por_cnt_r == POR_CYCLES - 1)
				power_on_pending_r <= 1'b0;
			por_cnt_r <= por_cnt_r + `ASMU_POR_CNT_STEP;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero
	always @*
	begin
		rdata_nxt = reg_rdata_out;
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				`ASMU_ADDR_STATUS: rdata_nxt = status_view;
				`ASMU_ADDR_MASK: rdata_nxt = mask_view;
				`ASMU_ADDR_POR: rdata_nxt = por_view;
				default: rdata_nxt = `ASMU_READ_ZERO;
			endcase
		end
	end

	// registered read data, one cycle after the strobe; holds between reads
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			reg_rdata_out <= `ASMU_RDATA_RESET;
		else
			reg_rdata_out <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// both pins are active low, as open-drain alarm lines usually are
	assign alert_n_out = ~alert_r;
	assign critical_temp_n_out = ~crit_r;

endmodule // asmu_alarm_status_mask_unit

/* inc/asmu_map.vh */
`ifndef ASMU_MAP_VH
`define ASMU_MAP_VH
// register addresses
`define ASMU_ADDR_STATUS 8'h02
`define ASMU_ADDR_MASK 8'h16
`define ASMU_ADDR_POR 8'h33
// status bit positions
`define ASMU_ST_BUSY 7
`define ASMU_ST_LOCAL_HI 6
`define ASMU_ST_REMOTE_HI 4
`define ASMU_ST_REMOTE_LO 3
`define ASMU_ST_DIODE 2
`define ASMU_ST_CRIT 1
`define ASMU_ST_TACH 0
`define ASMU_ST_UNUSED 5
// reset and idle values
`define ASMU_FLAGS_RESET 8'h00
`define ASMU_RDATA_RESET 8'h00
`define ASMU_READ_ZERO 8'h00
`define ASMU_POR_CNT_RESET 16'h0000
`define ASMU_POR_CNT_STEP 16'h0001
// status bits that can latch
`define ASMU_ST_LATCH_MASK 8'h5f
// mask register: writable bits and bits that read as one
`define ASMU_MASK_RW 8'h5b
`define ASMU_MASK_ONES 8'ha4
`define ASMU_MASK_RESET 8'h00
// alarms that may drive the alert pin
`define ASMU_ALERT_SRC 8'h5b
// power-on status bit
`define ASMU_POR_BIT 7
// power-on sequence length in clock cycles
`define ASMU_POR_CYCLES 16'h0010
`endif

/* tb/alarm_status_mask_unit_tb.sv */
`timescale 1ns/1ps
module alarm_status_mask_unit_tb;
	logic clk_sys_in = 1'b0, nrst_in = 1'b0, busy_in = 1'b0, diode_fault_in = 1'b0;
	logic alert_comparator_select_in = 1'b0, reg_wr_in, reg_rd_in, alert_n_out;
	logic critical_temp_n_out;
	logic [7:0] local_temp_in = 8'h32, local_high_in = 8'h32, remote_temp_in = 8'h3c;
	logic [7:0] remote_high_in = 8'h3c, remote_low_in = 8'h3c, critical_limit_in = 8'h46;
	logic [7:0] critical_hyst_in = 8'h05, reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [15:0] tach_count_in = 16'h00c8, tach_limit_in = 16'h00c8;
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	// 100 MHz
	always #5 clk_sys_in = ~clk_sys_in;
	asmu_alarm_status_mask_unit #(.POR_CYCLES(4)) DUT(.*);
	asmu_host u_host(.clk_sys_in, .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
		.reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in));
	task chk(input logic [7:0] g, e);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %h %h", $time, g, e);
		end
	endtask
	task rd(input logic [7:0] a, e);
		u_host.acc(1'b0, a, 8'h00);
		chk(reg_rdata_out, e);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, far above the roughly 60 cycles used
	always @(posedge clk_sys_in)
		if (++cyc > 2000)
		begin
			n_mismatch++;
			wrap_up;
		end
	// all sources except the critical compare start exactly at their setpoints
	initial
	begin
		repeat (8) @(posedge clk_sys_in);
		#1 nrst_in = 1'b1;
		rd(8'h33, 8'h80);
		rd(8'h02, 8'h00);
		u_host.acc(1'b1, 8'h16, 8'hff);
		rd(8'h16, 8'hff);
		local_temp_in = 8'h33;
		tach_count_in = 16'h00c9;
		rd(8'h02, 8'h41);
		chk({7'h00, alert_n_out}, 8'h01);
		local_temp_in = 8'h32;
		tach_count_in = 16'h00c8;
		u_host.acc(1'b1, 8'h16, 8'h00);
		rd(8'h16, 8'ha4);
		chk({7'h00, alert_n_out}, 8'h00);
		rd(8'h02, 8'h41);
		rd(8'h02, 8'h00);
		remote_temp_in = 8'h47;
		busy_in = 1'b1;
		rd(8'h02, 8'h92);
		remote_temp_in = 8'h41;
		rd(8'h02, 8'h92);
		chk({7'h00, critical_temp_n_out}, 8'h00);
		remote_temp_in = 8'h3b;
		busy_in = 1'b0;
		rd(8'h02, 8'h18);
		chk({7'h00, critical_temp_n_out}, 8'h01);
		remote_temp_in = 8'h3c;
		rd(8'h02, 8'h08);
		diode_fault_in = 1'b1;
		rd(8'h02, 8'h04);
		chk({7'h00, alert_n_out}, 8'h01);
		chk({7'h00, critical_temp_n_out}, 8'h01);
		diode_fault_in = 1'b0;
		rd(8'h02, 8'h04);
		alert_comparator_select_in = 1'b1;
		tach_count_in = 16'h00c9;
		rd(8'h02, 8'h01);
		chk({7'h00, alert_n_out}, 8'h00);
		tach_count_in = 16'h00c8;
		rd(8'h16, 8'ha4);
		chk({7'h00, alert_n_out}, 8'h01);
		alert_comparator_select_in = 1'b0;
		rd(8'h02, 8'h01);
		u_host.acc(1'b1, 8'h16, 8'h10);
		remote_temp_in = 8'h3d;
		rd(8'h02, 8'h10);
		chk({7'h00, alert_n_out}, 8'h01);
		remote_temp_in = 8'h3c;
		rd(8'h02, 8'h10);
		u_host.acc(1'b1, 8'h16, 8'h01);
		tach_count_in = 16'h00c9;
		rd(8'h02, 8'h01);
		chk({7'h00, alert_n_out}, 8'h01);
		tach_count_in = 16'h00c8;
		rd(8'h02, 8'h01);
		rd(8'h33, 8'h00);
		wrap_up;
	end
endmodule // alarm_status_mask_unit_tb

/* tb/asmu_chk.sv */
`timescale 1ns/1ps
module asmu_chk(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic busy_in,
	input wire logic [7:0] remote_temp_in,
	input wire logic [7:0] critical_limit_in,
	input wire logic [7:0] critical_hyst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic critical_temp_n_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	// hold zone in nine bits so a large hysteresis cannot wrap
	wire logic [7:0] a = reg_rd_in ? reg_addr_in : 8'h00;
	wire logic [7:0] q = reg_rdata_out;
	wire logic ov = remote_temp_in > critical_limit_in;
	wire logic hd = {1'b0, remote_temp_in} + critical_hyst_in >= critical_limit_in;
	wire logic c = critical_temp_n_out;
	property p_bz; a == 8'h02 |=> q[7] == $past(busy_in); endproperty
	a_bz: assert property (p_bz) else $error("busy bit");
	property p_s5; a == 8'h02 |=> !q[5]; endproperty
	a_s5: assert property (p_s5) else $error("status bit 5");
	property p_m1; a == 8'h16 |=> &(q | 8'h5b); endproperty
	a_m1: assert property (p_m1) else $error("mask ones");
	property p_po; a == 8'h33 |=> q[6:0] == 7'h00; endproperty
	a_po: assert property (p_po) else $error("power bits");
	property p_on; ov |=> !c; endproperty
	a_on: assert property (p_on) else $error("crit late");
	property p_f1; ov ##1 a == 8'h02 |=> q[1]; endproperty
	a_f1: assert property (p_f1) else $error("crit flag");
	property p_hd; !c && hd |=> !c; endproperty
	a_hd: assert property (p_hd) else $error("crit dropped");
	property p_rl; !c && !hd |=> c; endproperty
	a_rl: assert property (p_rl) else $error("crit stuck");
endmodule // asmu_chk

bind asmu_alarm_status_mask_unit asmu_chk u_chk(.clk_sys_in, .nrst_in, .busy_in,
	.remote_temp_in, .critical_limit_in, .critical_hyst_in, .reg_addr_in, .reg_rd_in,
	.reg_rdata_out, .critical_temp_n_out);

/* tb/asmu_host.sv */
`timescale 1ns/1ps
// host stand-in: one byte per access
module asmu_host(
	input wire logic clk_sys_in,
	output logic [7:0] reg_addr_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [7:0] reg_wdata_out
);
	initial {reg_addr_out, reg_wr_out, reg_rd_out, reg_wdata_out} = '0;
	// strobe spans one edge; address scrambled after so stale values never pass
	task acc(input logic w, input logic [7:0] a, d);
		@(posedge clk_sys_in) #1 {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {w, !w, a, d};
		@(posedge clk_sys_in) #1 {reg_wr_out, reg_rd_out, reg_addr_out} = {2'b00, ~a};
	endtask
endmodule // asmu_host
